// File: manchester_programming_link_tb.sv
module manchester_programming_link_tb;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int TW  = 50;
   localparam int TRG = 40;
   logic        mclk_i      = 1'b0;
   logic        sys_rst_i   = 1'b1;
   logic        prog_en_i   = 1'b0;
   logic        dev_id_i    = 1'b0;
   logic [31:0] mem_rdata_i = 32'h0;
   wire logic   line;
   logic        pin_o, pin_oe_o, mem_we_o, mem_nvm_o, mem_re_o, comm_mode_o, ev_v;
   logic [7:0]  mem_addr_o;
   logic [31:0] mem_wdata_o;
   logic [63:0] ev;
   logic [63:0] exp_q[$];
   int          fail_count = 0;
   int          tests_run  = 0;
   int          cyc        = 0;
   integer      seed       = 32'hf299cc95;

   always #2.5 mclk_i = ~mclk_i;

   mpl_link #(.TIMEOUT_CYC(500), .TW_CYC(TW), .TRIG_CYC(TRG)) dut (
      .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .line_i(line), .pin_o(pin_o),
      .pin_oe_o(pin_oe_o), .prog_en_i(prog_en_i), .dev_id_i(dev_id_i),
      .mem_rdata_i(mem_rdata_i), .mem_we_o(mem_we_o), .mem_nvm_o(mem_nvm_o),
      .mem_re_o(mem_re_o), .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
      .comm_mode_o(comm_mode_o));

   mpl_host host (.mclk_i(mclk_i), .pin_i(pin_o), .pin_oe_i(pin_oe_o), .line_o(line),
      .ev_v_o(ev_v), .ev_o(ev));

   // prints the counts and the verdict, then stops
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : test_done

   task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
      tests_run++;
      if (g !== e)
      begin
         fail_count++;
         $display("FAIL %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // matches a result seen at the ports against the oldest note
   task automatic take(input string nm, input logic [63:0] g);
      if (exp_q.size() == 0)
      begin
         fail_count++;
         $display("FAIL %s expected nothing seen %h", nm, g);
      end
      else
         chk(nm, exp_q.pop_front(), g);
   endtask : take

   // 3-bit check, seed all ones, msb first
   function automatic logic [2:0] crc3(input logic [42:0] b, input int n);
      logic [2:0] c;
      logic       fb;
      c = 3'h7;
      for (int i = n - 1; i >= 0; i--)
      begin
         fb = c[2] ^ b[i];
         c  = {c[1], c[0] ^ fb, fb};
      end
      return c;
   endfunction : crc3

   // one command frame; ok says the device should take it, bad spoils the check
   task automatic xfer(input logic rw, input logic [1:0] cs, input logic [7:0] a,
                       input logic [31:0] d, input int p, input logic ok, input logic bad);
      logic [31:0] rd;
      logic [42:0] b;
      logic [2:0]  c;
      int          w;
      rd = $random(seed);
      @(posedge mclk_i);
      mem_rdata_i <= rd;
      b = rw ? {32'h0, rw, cs, a} : {rw, cs, a, d};
      c = crc3(b, rw ? 11 : 43) ^ {2'h0, bad};
      if (ok && rw)
      begin
         exp_q.push_back({8'h03, 48'h0, a});
         exp_q.push_back({8'h02, 3'h0, 16'(37 * p), 2'h0, rd, crc3({11'h0, rd}, 32)});
      end
      if (ok && !rw)
      begin
         if (a != 8'h86)
            exp_q.push_back({8'h01, 15'h0, (a <= 8'h3f), a, d});
         exp_q.push_back({8'h02, 3'h0, 16'((a <= 8'h3f) ? TW : p), 37'h0});
      end
      if (rw)
         host.send({32'h0, 2'h0, b[10:0], c}, 16, p);
      else
         host.send({2'h0, b, c}, 48, p);
      // the host stays off the wire until the device lets go
      w = 0;
      while (pin_oe_o !== 1'b1 && w < 40)
      begin
         @(posedge mclk_i);
         w++;
      end
      while (pin_oe_o === 1'b1 && w < 4000)
      begin
         @(posedge mclk_i);
         w++;
      end
      repeat (3) @(posedge mclk_i);
   endtask : xfer

   // watches memory strobes and pin bursts
   always @(posedge mclk_i)
   begin
      if (mem_we_o === 1'b1 && mem_addr_o !== 8'h86)
         take("mem write", {8'h01, 15'h0, mem_nvm_o, mem_addr_o, mem_wdata_o});
      if (mem_re_o === 1'b1)
         take("mem read", {8'h03, 48'h0, mem_addr_o});
      if (ev_v === 1'b1)
         take("pin burst", ev);
   end

   // cuts a hang short
   always @(posedge mclk_i)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         fail_count++;
         $display("FAIL timeout expected end seen cycle %0d", cyc);
         test_done();
      end
   end

   // main sequence
   initial
   begin
      repeat (16) @(posedge mclk_i);
      sys_rst_i <= 1'b0;
      @(posedge mclk_i);
      chk("pin_oe_o", 0, pin_oe_o);
      chk("pin_o", 1, pin_o);
      chk("comm_mode_o", 0, comm_mode_o);
      $display("test reset done");
      prog_en_i <= 1'b1;
      repeat (3) @(posedge mclk_i);
      chk("comm_mode_o", 1, comm_mode_o);
      xfer(0, 2'h0, 8'h86, 32'hc2d8e67a, 8, 1, 0);
      for (int i = 0; i < 4; i++)
         xfer(0, 2'(i), 8'h40 + 8'(i), $random(seed), 8, i != 2, 0);
      xfer(0, 2'h1, 8'h3f, $random(seed), 8, 1, 0);
      $display("test writes done");
      dev_id_i <= 1'b1;
      xfer(1, 2'h2, 8'h91, 0, 8, 1, 0);
      xfer(1, 2'h1, 8'h91, 0, 8, 0, 0);
      xfer(1, 2'h3, 8'h05, 0, 12, 1, 0);
      xfer(1, 2'h0, 8'h22, 0, 8, 0, 1);
      xfer(0, 2'h0, 8'h50, $random(seed), 8, 0, 1);
      $display("test reads done");
      prog_en_i <= 1'b0;
      repeat (3) @(posedge mclk_i);
      xfer(0, 2'h0, 8'h60, $random(seed), 8, 0, 0);
      host.hold_low(TRG + 5);
      repeat (3) @(posedge mclk_i);
      chk("comm_mode_o", 1, comm_mode_o);
      xfer(0, 2'h0, 8'h86, mpl_pkg::ACCESS_KEY, 8, 1, 0);
      xfer(0, 2'h0, 8'h61, $random(seed), 8, 1, 0);
      xfer(1, 2'h0, 8'h61, 0, 8, 1, 0);
      $display("test trigger done");
      chk("notes left", 0, exp_q.size());
      test_done();
   end
endmodule : manchester_programming_link_tb

// File: mpl_host.sv
module mpl_host (
   input  wire logic        mclk_i,
   input  wire logic        pin_i,
   input  wire logic        pin_oe_i,
   output wire logic        line_o,
   output logic             ev_v_o,
   output logic [63:0]      ev_o
);
   timeunit 1ns;
   timeprecision 1ps;

   logic        low_q  = 1'b0;
   logic [15:0] cnt_q  = 16'h0;
   logic [36:0] bits_q = 37'h0;
   int          per    = 8;

   // wire with pull-up, low while either party pulls it down
   assign line_o = ~(low_q | (pin_oe_i & ~pin_i));

   // sends one frame msb first, each bit coded by its first-half level
   task automatic send(input logic [47:0] f, input int n, input int p);
      per = p;
      for (int i = n - 1; i >= 0; i--)
      begin
         for (int h = 0; h < 2; h++)
         begin
            repeat (p / 2) @(posedge mclk_i) low_q <= f[i] ^ (h == 0);
         end
      end
      @(posedge mclk_i) low_q <= 1'b0;
   endtask : send

   // holds the wire low for n cycles, then lets the pull-up raise it
   task automatic hold_low(input int n);
      @(posedge mclk_i) low_q <= 1'b1;
      repeat (n) @(posedge mclk_i);
      low_q <= 1'b0;
   endtask : hold_low

   // measures each device burst and samples the first half of every bit
   always @(posedge mclk_i)
   begin
      ev_v_o <= 1'b0;
      if (pin_oe_i === 1'b1)
      begin
         cnt_q <= cnt_q + 16'h1;
         if (int'(cnt_q) % per == per / 4)
         begin
            bits_q <= {bits_q[35:0], line_o};
         end
      end
      else if (cnt_q != 16'h0)
      begin
         ev_o   <= {8'h02, 3'h0, cnt_q, bits_q};
         ev_v_o <= 1'b1;
         cnt_q  <= 16'h0;
         bits_q <= 37'h0;
      end
   end
endmodule : mpl_host

// File: mpl_link.sv
// Functional notes
// - Traffic uses the one output pin, the supply-driven enable gates access, ground reference.
// - A long low then release on the pin alone opens a timed session window.
// - A non-volatile write holds the pin low for the write time, then releases it to rise.
// - The device only answers frames and never starts a transfer.
// - A successful write is acknowledged with a low pulse on the pin.
// - A read is answered with the register word in a read-acknowledge frame.
// - A zero is a rising edge and a one a falling edge in the middle of the bit.
// - Address and data travel most significant bit first.
// - Access code, volatile write, non-volatile write and read are decoded.
// - The exchange works whatever normal output protocol is configured.
// - A command holds sync 00, read/write, chip select, address, write data, check bits.
// - The bit period is measured from the sync bits and reused for the response.
// - The 3-bit check covers all bits but the sync, seeded with all ones, sent last.
// - Chip select 01 is device 0, 10 is device 1, 00 and 11 reach every die.
module mpl_link #(
   parameter int unsigned TIMEOUT_CYC = mpl_pkg::TIMEOUT_CYC,
   parameter int unsigned TW_CYC      = mpl_pkg::TW_CYC,
   parameter int unsigned TRIG_CYC    = mpl_pkg::TRIG_CYC,
   parameter int unsigned CNT_W       = 24
) (
   input  wire logic        mclk_i,
   input  wire logic        sys_rst_i,
   input  wire logic        line_i,
   output logic             pin_o,
   output logic             pin_oe_o,
   input  wire logic        prog_en_i,
   input  wire logic        dev_id_i,
   input  wire logic [31:0] mem_rdata_i,
   output logic             mem_we_o,
   output logic             mem_nvm_o,
   output logic             mem_re_o,
   output logic [7:0]       mem_addr_o,
   output logic [31:0]      mem_wdata_o,
   output logic             comm_mode_o
);
   typedef enum logic [6:0] {
      S_IDLE = 7'h01,
      S_SYNC = 7'h02,
      S_BITS = 7'h04,
      S_EXEC = 7'h08,
      S_READ = 7'h10,
      S_SEND = 7'h20,
      S_ACK  = 7'h40
   } mpl_state_t;

   mpl_state_t       state_q, state_d;
   logic [15:0]      cnt_q, cnt_d, per_q, per_d;
   logic             edge_q, edge_d, smp_q, smp_d, rw_q, rw_d, line_q;
   logic [5:0]       nbits_q, nbits_d;
   logic [45:0]      sh_q, sh_d;
   logic [2:0]       crc_q, crc_d;
   logic [CNT_W-1:0] ack_q, ack_d, win_cnt_q, win_cnt_d, low_q, low_d;
   logic             win_q, win_d, unl_q, unl_d;
   logic             pin_d, oe_d, we_d, nvm_d, re_d, comm_d, go_q, go_d;
   logic [7:0]       addr_d;
   logic [31:0]      wdat_d, rdat_q, rdat_d;
   logic             fall, rise, listen, crc_ok, cs_hit, tx_line, tx_busy;
   logic [1:0]       cs;
   logic [7:0]       addr;
   logic [31:0]      data;
   logic [5:0]       len;
   logic [15:0]      q3;

   // line edges and field views of the received frame
   assign fall   = line_q & ~line_i;
   assign rise   = line_i & ~line_q;
   assign listen = prog_en_i | unl_q | win_q;
   assign len    = rw_q ? mpl_pkg::RD_LEN : mpl_pkg::WR_LEN;
   assign q3     = per_q - {2'b00, per_q[15:2]};
   assign cs     = rw_q ? sh_q[12:11] : sh_q[44:43];
   assign addr   = rw_q ? sh_q[10:3] : sh_q[42:35];
   assign data   = sh_q[34:3];
   assign crc_ok = sh_q[2:0] == crc_q;
   assign cs_hit = cs == 2'h0 || cs == 2'h3 ||
                   cs == (dev_id_i ? mpl_pkg::CS_DEV1 : mpl_pkg::CS_DEV0);

   // session window opened by a long low on the pin
   always_comb
   begin
      low_d     = line_i ? '0 : ((&low_q) ? low_q : low_q + 1'b1);
      win_d     = win_q;
      win_cnt_d = win_cnt_q;
      if (!listen && rise && low_q >= CNT_W'(TRIG_CYC))
      begin
         win_d     = 1'b1;
         win_cnt_d = '0;
      end
      else if (win_q && state_q == S_IDLE)
      begin
         win_cnt_d = win_cnt_q + 1'b1;
         if (win_cnt_q == CNT_W'(TIMEOUT_CYC - 1))
         begin
            win_d = 1'b0;
         end
      end
      else if (state_q == S_EXEC)
      begin
         win_d = 1'b0;
      end
   end

   // frame receiver, command decoder and answer sequencing
   always_comb
   begin
      state_d = state_q;
      cnt_d   = (&cnt_q) ? cnt_q : cnt_q + 16'h1;
      per_d   = per_q;
      edge_d  = edge_q;
      smp_d   = smp_q;
      rw_d    = rw_q;
      nbits_d = nbits_q;
      sh_d    = sh_q;
      crc_d   = crc_q;
      ack_d   = ack_q;
      unl_d   = unl_q;
      we_d    = 1'b0;
      re_d    = 1'b0;
      go_d    = 1'b0;
      nvm_d   = mem_nvm_o;
      addr_d  = mem_addr_o;
      wdat_d  = mem_wdata_o;
      rdat_d  = rdat_q;
      case (state_q)
         S_IDLE:
         begin
            if (listen && fall)
            begin
               cnt_d   = 16'h0;
               edge_d  = 1'b0;
               state_d = S_SYNC;
            end
         end
         S_SYNC:
         begin
            if (&cnt_q)
            begin
               state_d = S_IDLE;
            end
            else if (fall && !edge_q)
            begin
               per_d  = cnt_q + 16'h1;
               edge_d = 1'b1;
               if (cnt_q < 16'(mpl_pkg::PER_MIN - 1))
               begin
                  state_d = S_IDLE;
               end
            end
            else if (rise && edge_q)
            begin
               cnt_d   = 16'h0;
               smp_d   = 1'b0;
               nbits_d = 6'h0;
               crc_d   = mpl_pkg::CRC_SEED;
               state_d = S_BITS;
            end
         end
         S_BITS:
         begin
            if (!smp_q && cnt_q == q3)
            begin
               // first-half level is the bit value
               sh_d    = {sh_q[44:0], line_i};
               nbits_d = nbits_q + 6'h1;
               smp_d   = 1'b1;
               if (nbits_q == 6'h0)
               begin
                  rw_d = line_i;
               end
               if (nbits_q < len - 6'h3)
               begin
                  crc_d = mpl_pkg::crc_step(crc_q, line_i);
               end
            end
            else if (smp_q && line_i != line_q)
            begin
               cnt_d   = 16'h0;
               smp_d   = 1'b0;
               if (nbits_q == len)
               begin
                  state_d = S_EXEC;
               end
            end
            else if (cnt_q >= per_q + per_q)
            begin
               state_d = S_IDLE;
            end
         end
         S_EXEC:
         begin
            state_d = S_IDLE;
            addr_d  = addr;
            if (crc_ok && cs_hit)
            begin
               if (rw_q)
               begin
                  re_d    = 1'b1;
                  state_d = S_READ;
               end
               else if (addr == mpl_pkg::ADDR_ACCESS)
               begin
                  if (data[31:1] == mpl_pkg::ACCESS_KEY[31:1])
                  begin
                     unl_d   = data[0];
                     ack_d   = CNT_W'(per_q) - 1'b1;
                     state_d = S_ACK;
                  end
               end
               else if (unl_q || prog_en_i)
               begin
                  we_d    = 1'b1;
                  wdat_d  = data;
                  nvm_d   = addr <= mpl_pkg::NVM_TOP;
                  ack_d   = (addr <= mpl_pkg::NVM_TOP) ? CNT_W'(TW_CYC - 1) :
                            CNT_W'(per_q) - 1'b1;
                  state_d = S_ACK;
               end
            end
         end
         S_READ:
         begin
            rdat_d  = mem_rdata_i;
            go_d    = 1'b1;
            state_d = S_SEND;
         end
         S_SEND:
         begin
            if (!go_q && !tx_busy)
            begin
               state_d = S_IDLE;
            end
         end
         S_ACK:
         begin
            ack_d = ack_q - 1'b1;
            if (ack_q == '0)
            begin
               state_d = S_IDLE;
            end
         end
         default:
         begin
            state_d = S_IDLE;
         end
      endcase
      // pin driven only while answering; the ack holds it low
      pin_d  = tx_busy ? tx_line : 1'b0;
      oe_d   = tx_busy || state_q == S_ACK;
      comm_d = listen;
   end

   // registers of the link
   always_ff @(posedge mclk_i)
   begin
      if (sys_rst_i)
      begin
         state_q     <= S_IDLE;
         cnt_q       <= 16'h0;
         per_q       <= 16'h0;
         edge_q      <= 1'b0;
         smp_q       <= 1'b0;
         rw_q        <= 1'b0;
         line_q      <= 1'b1;
         nbits_q     <= 6'h0;
         sh_q        <= 46'h0;
         crc_q       <= 3'h0;
         ack_q       <= '0;
         win_cnt_q   <= '0;
         low_q       <= '0;
         win_q       <= 1'b0;
         unl_q       <= 1'b0;
         go_q        <= 1'b0;
         rdat_q      <= 32'h0;
         pin_o       <= 1'b1;
         pin_oe_o    <= 1'b0;
         mem_we_o    <= 1'b0;
         mem_nvm_o   <= 1'b0;
         mem_re_o    <= 1'b0;
         mem_addr_o  <= 8'h0;
         mem_wdata_o <= 32'h0;
         comm_mode_o <= 1'b0;
      end
      else
      begin
         state_q     <= state_d;
         cnt_q       <= cnt_d;
         per_q       <= per_d;
         edge_q      <= edge_d;
         smp_q       <= smp_d;
         rw_q        <= rw_d;
         line_q      <= line_i;
         nbits_q     <= nbits_d;
         sh_q        <= sh_d;
         crc_q       <= crc_d;
         ack_q       <= ack_d;
         win_cnt_q   <= win_cnt_d;
         low_q       <= low_d;
         win_q       <= win_d;
         unl_q       <= unl_d;
         go_q        <= go_d;
         rdat_q      <= rdat_d;
         pin_o       <= pin_d;
         pin_oe_o    <= oe_d;
         mem_we_o    <= we_d;
         mem_nvm_o   <= nvm_d;
         mem_re_o    <= re_d;
         mem_addr_o  <= addr_d;
         mem_wdata_o <= wdat_d;
         comm_mode_o <= comm_d;
      end
   end

   // response serialiser at the measured bit period, counted in half periods
   mpl_tx u_tx (
      .mclk_i    (mclk_i),
      .sys_rst_i (sys_rst_i),
      .start_i   (go_q),
      .data_i    (rdat_q),
      .half_i    (per_q[15:1]),
      .line_o    (tx_line),
      .busy_o    (tx_busy)
   );

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (sys_rst_i);

   sequence ack_last_s;
      state_q == S_ACK && ack_q == '0;
   endsequence
   sequence release_s;
      pin_oe_o ##1 !pin_oe_o;
   endsequence

   ack_low_a: assert property (state_q == S_ACK |=> pin_oe_o && !pin_o)
      else $error("acknowledge does not hold the pin low");
   responder_a: assert property (pin_oe_o |-> $past(state_q) != S_IDLE || tx_busy)
      else $error("pin driven without a frame");
   read_tx_a: assert property (state_q == S_READ |=> ##1 tx_busy)
      else $error("read not answered");
   crc_drop_a: assert property (state_q == S_EXEC && !crc_ok |=> ##1 !pin_oe_o)
      else $error("bad frame answered");
   cs_drop_a: assert property (state_q == S_EXEC && !cs_hit |=> !mem_we_o && !mem_re_o)
      else $error("other die selected yet accessed");
   nvm_time_a: assert property (mem_we_o && mem_nvm_o |-> ack_q == CNT_W'(TW_CYC - 1))
      else $error("non-volatile hold time wrong");
   nvm_rise_a: assert property (ack_last_s |=> release_s)
      else $error("pin not released after hold");
   locked_wr_a: assert property (state_q == S_EXEC && !rw_q && !unl_q && !prog_en_i
      |=> !mem_we_o)
      else $error("write accepted while locked");
endmodule : mpl_link

// File: mpl_pkg.sv
package mpl_pkg;
   // clock rate, long timing figures and the shortest bit period
   localparam int unsigned CLK_MHZ     = 200;
   localparam int unsigned TIMEOUT_US  = 300;
   localparam int unsigned TIMEOUT_CYC = TIMEOUT_US * CLK_MHZ;
   localparam int unsigned TW_US       = 100;
   localparam int unsigned TW_CYC      = TW_US * CLK_MHZ;
   localparam int unsigned TRIG_US     = 20;
   localparam int unsigned TRIG_CYC    = TRIG_US * CLK_MHZ;
   localparam int unsigned PER_MIN     = 4;
   // frame lengths after the two sync bits, and response bit indices from the first sync bit
   localparam logic [5:0]  RD_LEN      = 6'h0e;
   localparam logic [5:0]  WR_LEN      = 6'h2e;
   localparam logic [5:0]  TX_LAST     = 6'h24;
   localparam logic [5:0]  TX_CRC_AT   = 6'h22;
   localparam logic [5:0]  TX_DAT_AT   = 6'h02;
   // field codes
   localparam logic [2:0]  CRC_SEED    = 3'h7;
   localparam logic [1:0]  CS_DEV0     = 2'h1;
   localparam logic [1:0]  CS_DEV1     = 2'h2;
   localparam logic [7:0]  ADDR_ACCESS = 8'h86;
   localparam logic [7:0]  NVM_TOP     = 8'h3f;
   localparam logic [31:0] ACCESS_KEY  = 32'hc2d8e67b;

   // one step of the 3-bit frame check, polynomial x^3 + x + 1
   function automatic logic [2:0] crc_step(input logic [2:0] c, input logic b);
      logic fb;
      fb = c[2] ^ b;
      return {c[1], c[0] ^ fb, fb};
   endfunction : crc_step
endpackage : mpl_pkg

// File: mpl_tx.sv
module mpl_tx (
   input  wire logic        mclk_i,
   input  wire logic        sys_rst_i,
   input  wire logic        start_i,
   input  wire logic [31:0] data_i,
   input  wire logic [14:0] half_i,
   output logic             line_o,
   output logic             busy_o
);
   logic        busy_q, busy_d;
   logic [33:0] sh_q, sh_d;
   logic [2:0]  crc_q, crc_d;
   logic [5:0]  idx_q, idx_d;
   logic        ph_q, ph_d;
   logic [14:0] cnt_q, cnt_d;
   logic        cur;

   // current bit: sync and data from the shifter, then the check bits
   assign cur    = (idx_q < mpl_pkg::TX_CRC_AT) ? sh_q[33] : crc_q[2];
   // first half carries the bit, second half its inverse
   assign line_o = busy_q ? (cur ^ ph_q) : 1'b1;
   assign busy_o = busy_q;

   // serialiser next state
   always_comb
   begin
      busy_d = busy_q;
      sh_d   = sh_q;
      crc_d  = crc_q;
      idx_d  = idx_q;
      ph_d   = ph_q;
      cnt_d  = cnt_q + 15'h1;
      if (start_i && !busy_q)
      begin
         busy_d = 1'b1;
         sh_d   = {2'b00, data_i};
         crc_d  = mpl_pkg::CRC_SEED;
         idx_d  = 6'h0;
         ph_d   = 1'b0;
         cnt_d  = 15'h0;
      end
      else if (busy_q && cnt_q == half_i - 15'h1)
      begin
         cnt_d = 15'h0;
         ph_d  = ~ph_q;
         if (ph_q)
         begin
            idx_d = idx_q + 6'h1;
            if (idx_q < mpl_pkg::TX_CRC_AT)
            begin
               sh_d = {sh_q[32:0], 1'b0};
               if (idx_q >= mpl_pkg::TX_DAT_AT)
               begin
                  crc_d = mpl_pkg::crc_step(crc_q, cur);
               end
            end
            else
            begin
               crc_d = {crc_q[1:0], 1'b0};
            end
            if (idx_q == mpl_pkg::TX_LAST)
            begin
               busy_d = 1'b0;
            end
         end
      end
      else if (!busy_q)
      begin
         cnt_d = 15'h0;
      end
   end

   // serialiser registers
   always_ff @(posedge mclk_i)
   begin
      if (sys_rst_i)
      begin
         busy_q <= 1'b0;
         sh_q   <= 34'h0;
         crc_q  <= 3'h0;
         idx_q  <= 6'h0;
         ph_q   <= 1'b0;
         cnt_q  <= 15'h0;
      end
      else
      begin
         busy_q <= busy_d;
         sh_q   <= sh_d;
         crc_q  <= crc_d;
         idx_q  <= idx_d;
         ph_q   <= ph_d;
         cnt_q  <= cnt_d;
      end
   end

   mid_edge_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      busy_q && !ph_q && cnt_q == half_i - 15'h1 |=> line_o != $past(line_o))
      else $error("no mid-bit transition");
   sync_low_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      start_i && !busy_q |=> !line_o && busy_o)
      else $error("response does not open with a zero sync bit");
   msb_load_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      start_i && !busy_q |=> sh_q[33] == 1'b0 && sh_q[31:0] == $past(data_i))
      else $error("data word not loaded msb first");
endmodule : mpl_tx
